// ==== verilog/npl_consts.vh ====
// Constants of the configuration loader: store word addresses,
// field positions, reset values, register offsets and timing counts.
// Included by the store reader, the loader and the bench files; definitions only.
`ifndef NPL_CONSTS_VH
`define NPL_CONSTS_VH

// Word addresses inside the integrated configuration store
`define NPL_PIN_WORD_ADDR 8'h20
`define NPL_FUNC_WORD_ADDR 8'h21

// Field positions in the pin-control word
`define NPL_PIN_LVL0 0
`define NPL_PIN_LVL1 1
`define NPL_PIN_COLD_ADV 2
`define NPL_PIN_GIGA_OFF 3
`define NPL_PIN_DIR0 8
`define NPL_PIN_DIR1 9

// Field positions in the functions-control word
`define NPL_FUNC_PREF 9
`define NPL_FUNC_NARROW 10
// Bits kept from the functions-control word: narrow mode and prefetch
`define NPL_FUNC_KEEP 16'h0600

// Hardware defaults used before and instead of a stored word
`define NPL_PIN_WORD_RST 16'h000C
`define NPL_FUNC_WORD_RST 16'h0400

// Register byte offsets on the bus
`define NPL_OFS_CTRL 8'h00
`define NPL_OFS_PWRCAP 8'h04
`define NPL_OFS_BASE_ADDRESS_CONTROL_REGISTER 8'h08
`define NPL_OFS_STATUS 8'h0C
`define NPL_OFS_RAW 8'h10

// Field positions in the device control register
`define NPL_CTRL_LVL0 0
`define NPL_CTRL_LVL1 1
`define NPL_CTRL_DIR0 2
`define NPL_CTRL_DIR1 3
`define NPL_CTRL_COLD_ADV 4

// Bus responses
`define NPL_RESP_OKAY 2'h0
`define NPL_RESP_SLVERR 2'h2

// Store answer timeout: longest wait, rounded down to cycles
`define NPL_CLK_PERIOD_NS 5
`define NPL_STORE_TIMEOUT_NS 1000
// 1000 ns at 5 ns a cycle, sized for the 8-bit wait timer
`define NPL_STORE_TIMEOUT_CYC 8'hC8

`endif

// ==== verilog/npl_pin_sync.v ====
// Three-stage synchroniser with agreement filter for pin inputs.
// Assumes inputs asynchronous to sys_clk; output follows once the
// second and third stages agree.
`timescale 1ns/1ps
module npl_pin_sync #(
  parameter WIDTH = 1
) (
  // Clock, reset, enable
  input wire sys_clk,
  input wire reset,
  input wire ce,
  // Raw pin levels
  input wire [WIDTH-1:0] pinIn,
  // Filtered levels
  output reg [WIDTH-1:0] levelOut
);

  reg [WIDTH-1:0] stageOne_reg; // Read only by stage two
  reg [WIDTH-1:0] stageTwo_reg;
  reg [WIDTH-1:0] stageThree_reg;

  // Shift chain and agreement filter, one bit at a time
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : gBit
      always @(posedge sys_clk)
      begin
        if (reset)
        begin
          stageOne_reg[i] <= 1'b0;
          stageTwo_reg[i] <= 1'b0;
          stageThree_reg[i] <= 1'b0;
          levelOut[i] <= 1'b0;
        end
        else if (ce)
        begin
          stageOne_reg[i] <= pinIn[i];
          stageTwo_reg[i] <= stageOne_reg[i];
          stageThree_reg[i] <= stageTwo_reg[i];
          // Accept a change only when two stages agree
          if (stageTwo_reg[i] == stageThree_reg[i])
            levelOut[i] <= stageThree_reg[i];
        end
      end
    end
  endgenerate

endmodule

// ==== verilog/npl_store_reader.v ====
// Single-word reader for the integrated configuration store.
// Assumes the store sits on sys_clk and answers a held read enable
// with a one-cycle valid; gives up after a fixed timeout.
`timescale 1ns/1ps
`include "npl_consts.vh"
module npl_store_reader (
  // Clock, reset, enable
  input wire sys_clk,
  input wire reset,
  input wire ce,
  // Request from the loader
  input wire start,
  input wire [7:0] wordAddr,
  output reg done,
  output reg timedOut,
  output reg [15:0] wordData,
  // Store read port
  output wire storeRdEn,
  output reg [7:0] storeAddr,
  input wire storeRdValid,
  input wire [15:0] storeRdData
);

  localparam [7:0] TIMEOUT_MAX = `NPL_STORE_TIMEOUT_CYC;

  reg busy_reg; // Read under way
  reg [7:0] timer_reg; // Cycles waited so far

  // Enable stays high until the store answers or the wait times out
  assign storeRdEn = busy_reg;

  // Request, wait and capture
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      busy_reg <= 1'b0;
      timer_reg <= 8'h00;
      storeAddr <= 8'h00;
      wordData <= 16'h0000;
      done <= 1'b0;
      timedOut <= 1'b0;
    end
    else if (ce)
    begin
      done <= 1'b0;
      timedOut <= 1'b0;
      if (!busy_reg)
      begin
        // Latch the word address on start
        if (start)
        begin
          busy_reg <= 1'b1;
          storeAddr <= wordAddr;
          timer_reg <= 8'h00;
        end
      end
      else if (storeRdValid)
      begin
        // Store answered
        busy_reg <= 1'b0;
        wordData <= storeRdData;
        done <= 1'b1;
      end
      else if (timer_reg == TIMEOUT_MAX)
      begin
        // No answer: report and let the loader keep defaults
        busy_reg <= 1'b0;
        done <= 1'b1;
        timedOut <= 1'b1;
      end
      else
        timer_reg <= timer_reg + 8'h01;
    end
  end

endmodule

// ==== verilog/npl_config_loader.v ====
// Configuration loader: reads the pin-control and functions-control
// words after reset and applies them to the live device state.
// Assumes a same-clock store port, an AXI4-Lite master that waits
// for answers, and asynchronous pin and auxiliary power inputs.
//
// How it works
// - Gigabit off outside full-power state when set
// - Bit 2 decides cold-sleep wake capability report
// - Bit 2 copied into control advertise bit
// - Advertised only while auxiliary power present
// - Advertise bit clear never reports capability
// - Bit 1 sets soft pin one level
// - Bit 0 sets soft pin zero level
// - Bit 10 selects legacy 32-bit base mode
// - Bit 9 marks base registers prefetchable
// - Register space has read side effects
// - Prefetchable marking only from stored word
// - Direction bits set pins; levels drive outputs
`timescale 1ns/1ps
`include "npl_consts.vh"
module npl_config_loader (
  // Clock, reset, enable
  input wire sys_clk,
  input wire reset,
  input wire ce,
  // Store read port
  output wire storeRdEn,
  output wire [7:0] storeAddr,
  input wire storeRdValid,
  input wire [15:0] storeRdData,
  // Power state and auxiliary power pin
  input wire inActiveFullPower,
  input wire auxPowerPresentPin,
  // Derived device state
  output reg gigabitDisable,
  output wire coldWakeCapable,
  output wire legacyNarrowBaseMode,
  output wire prefetchableBaseMarking,
  output reg loadDone,
  // Soft pins 0 and 1, two-way
  input wire [1:0] softPinIn,
  output wire [1:0] softPinOut,
  output wire [1:0] softPinOe,
  // AXI4-Lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  // Loader states
  localparam [2:0] ST_START = 3'h0;
  localparam [2:0] ST_PIN = 3'h1;
  localparam [2:0] ST_PIN_WAIT = 3'h2;
  localparam [2:0] ST_FUNC = 3'h3;
  localparam [2:0] ST_FUNC_WAIT = 3'h4;
  localparam [2:0] ST_DONE = 3'h5;

  // Register decode: offset known to the map
  function mapped;
    input [7:0] ofs;
    begin
      mapped = (ofs == `NPL_OFS_CTRL) || (ofs == `NPL_OFS_PWRCAP) ||
        (ofs == `NPL_OFS_BASE_ADDRESS_CONTROL_REGISTER) || (ofs == `NPL_OFS_STATUS) ||
        (ofs == `NPL_OFS_RAW);
    end
  endfunction

  reg [2:0] state_reg; // Loader state
  reg [2:0] state_next;
  reg readerStart; // One-cycle start to the reader
  reg [7:0] readerAddr; // Word to fetch
  wire readerDone; // Reader finished
  wire readerTimedOut; // Store never answered
  wire [15:0] readerData; // Word fetched
  reg [15:0] pinWord_reg; // Applied pin-control word
  reg [15:0] funcWord_reg; // Applied functions-control word
  reg storeError_reg; // Sticky store timeout
  reg [4:0] ctrl_reg; // Device control register bits
  reg auxChanged_reg; // Sticky aux power change, clear on read
  reg auxSeen_reg; // Last filtered aux level
  wire auxPresent; // Filtered aux power level
  wire [1:0] pinLevel; // Filtered soft pin levels
  reg awHeld_reg; // Write address captured
  reg wHeld_reg; // Write data captured
  reg [7:0] awAddr_reg;
  reg [31:0] wData_reg;
  reg [3:0] wStrb_reg;
  reg [31:0] readValue; // Read mux output
  wire doWrite; // Both halves of a write in hand
  wire doRead; // Read address taken
  wire statusRead; // Read of the status word
  // Store word fetcher
  npl_store_reader uReader (.sys_clk(sys_clk), .reset(reset), .ce(ce),
    .start(readerStart), .wordAddr(readerAddr), .done(readerDone),
    .timedOut(readerTimedOut), .wordData(readerData),
    .storeRdEn(storeRdEn), .storeAddr(storeAddr),
    .storeRdValid(storeRdValid), .storeRdData(storeRdData));
  // Pin synchronisers: aux power and two soft pins
  npl_pin_sync #(.WIDTH(3)) uSync (.sys_clk(sys_clk), .reset(reset),
    .ce(ce), .pinIn({auxPowerPresentPin, softPinIn}),
    .levelOut({auxPresent, pinLevel}));
  // Loader sequence: pin word, then function word, once
  always @*
  begin
    state_next = state_reg;
    readerStart = 1'b0;
    readerAddr = `NPL_PIN_WORD_ADDR;
    case (state_reg)
      ST_START:
        state_next = ST_PIN;
      ST_PIN:
      begin
        readerStart = 1'b1;
        state_next = ST_PIN_WAIT;
      end
      ST_PIN_WAIT:
        if (readerDone)
          state_next = ST_FUNC;
      ST_FUNC:
      begin
        readerStart = 1'b1;
        readerAddr = `NPL_FUNC_WORD_ADDR;
        state_next = ST_FUNC_WAIT;
      end
      ST_FUNC_WAIT:
        if (readerDone)
          state_next = ST_DONE;
      ST_DONE:
        state_next = ST_DONE;
      default:
        state_next = ST_START;
    endcase
  end

  // Loader registers and applied words
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      state_reg <= ST_START;
      pinWord_reg <= `NPL_PIN_WORD_RST;
      funcWord_reg <= `NPL_FUNC_WORD_RST;
      storeError_reg <= 1'b0;
      loadDone <= 1'b0;
    end
    else if (ce)
    begin
      state_reg <= state_next;
      // Timeout keeps the hardware default word
      if (readerDone && readerTimedOut)
        storeError_reg <= 1'b1;
      if (readerDone && !readerTimedOut && state_reg == ST_PIN_WAIT)
        pinWord_reg <= readerData;
      // Only bits 10 and 9 are kept
      if (readerDone && !readerTimedOut && state_reg == ST_FUNC_WAIT)
        funcWord_reg <= readerData & `NPL_FUNC_KEEP;
      // Registers open to the host once both words are
      if (state_reg == ST_DONE)
        loadDone <= 1'b1;
    end
  end
  // Base address marking comes from the stored word, or from the hardware default on a timeout
  assign legacyNarrowBaseMode = funcWord_reg[`NPL_FUNC_NARROW];
  // No runtime path alters this marking
  assign prefetchableBaseMarking = funcWord_reg[`NPL_FUNC_PREF];
  // Capability needs both the advertise bit and aux power
  assign coldWakeCapable = pinWord_reg[`NPL_PIN_COLD_ADV] & auxPresent;
  // Gigabit block outside the full-power state
  always @(posedge sys_clk)
  begin
    if (reset)
      gigabitDisable <= 1'b1;
    else if (ce)
      gigabitDisable <= pinWord_reg[`NPL_PIN_GIGA_OFF] &
        !inActiveFullPower;
  end
  // Soft pins drive their level only as outputs
  assign softPinOut = {ctrl_reg[`NPL_CTRL_LVL1], ctrl_reg[`NPL_CTRL_LVL0]};
  assign softPinOe = {ctrl_reg[`NPL_CTRL_DIR1], ctrl_reg[`NPL_CTRL_DIR0]};
  // Bus handshakes: held off until load is complete, and while frozen
  assign s_axi_awready = ce && loadDone && !awHeld_reg && !s_axi_bvalid;
  assign s_axi_wready = ce && loadDone && !wHeld_reg && !s_axi_bvalid;
  assign s_axi_arready = ce && loadDone && !s_axi_rvalid;
  assign doWrite = awHeld_reg && wHeld_reg;
  assign doRead = s_axi_arvalid && s_axi_arready;
  assign statusRead = doRead && (s_axi_araddr == `NPL_OFS_STATUS);

  // Write channel capture and response
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      awAddr_reg <= 8'h00;
      wData_reg <= 32'h00000000;
      wStrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `NPL_RESP_OKAY;
    end
    else if (ce)
    begin
      // Address and data in either order
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHeld_reg <= 1'b1;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end
      // Response once both halves are in
      if (doWrite)
      begin
        awHeld_reg <= 1'b0;
        wHeld_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(awAddr_reg) ? `NPL_RESP_OKAY :
          `NPL_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Device control register: loaded, then software writable
  always @(posedge sys_clk)
  begin
    if (reset)
      ctrl_reg <= 5'h00;
    else if (ce)
    begin
      if (state_reg == ST_FUNC)
      begin
        // Pin word applied before the host can reach it
        ctrl_reg[`NPL_CTRL_LVL0] <= pinWord_reg[`NPL_PIN_LVL0];
        ctrl_reg[`NPL_CTRL_LVL1] <= pinWord_reg[`NPL_PIN_LVL1];
        ctrl_reg[`NPL_CTRL_DIR0] <= pinWord_reg[`NPL_PIN_DIR0];
        ctrl_reg[`NPL_CTRL_DIR1] <= pinWord_reg[`NPL_PIN_DIR1];
        ctrl_reg[`NPL_CTRL_COLD_ADV] <=
          pinWord_reg[`NPL_PIN_COLD_ADV];
      end
      else if (doWrite && awAddr_reg == `NPL_OFS_CTRL && wStrb_reg[0])
        // Levels and directions only; advertise bit stays read-only
        ctrl_reg[3:0] <= wData_reg[3:0];
    end
  end

  // Aux power change flag; a change wins over the clearing read
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      auxSeen_reg <= 1'b0;
      auxChanged_reg <= 1'b0;
    end
    else if (ce)
    begin
      auxSeen_reg <= auxPresent;
      if (auxSeen_reg != auxPresent)
        auxChanged_reg <= 1'b1;
      else if (statusRead)
        // Reading clears it, so the space must not be prefetched
        auxChanged_reg <= 1'b0;
    end
  end

  // Read data mux
  always @*
  begin
    case (s_axi_araddr)
      `NPL_OFS_CTRL:
        readValue = {27'h0000000, ctrl_reg};
      `NPL_OFS_PWRCAP:
        readValue = {31'h00000000, coldWakeCapable};
      `NPL_OFS_BASE_ADDRESS_CONTROL_REGISTER:
        readValue = {30'h00000000, prefetchableBaseMarking,
          legacyNarrowBaseMode};
      `NPL_OFS_STATUS:
        readValue = {24'h000000, pinLevel, auxChanged_reg, auxPresent,
          gigabitDisable, storeError_reg, inActiveFullPower, loadDone};
      `NPL_OFS_RAW:
        readValue = {funcWord_reg, pinWord_reg};
      default:
        readValue = 32'h00000000;
    endcase
  end
  // Read answer, one cycle after the address is taken
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `NPL_RESP_OKAY;
    end
    else if (ce)
    begin
      if (doRead)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= readValue;
        s_axi_rresp <= mapped(s_axi_araddr) ? `NPL_RESP_OKAY :
          `NPL_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ==== dv/npl_store_model.sv ====
// Behavioural model of the integrated configuration store.
// Assumes one clock shared with the loader; answers a held read.
`timescale 1ns/1ps
`include "npl_consts.vh"
module npl_store_model (
  // Clock
  input wire sys_clk,
  // Read port
  input wire storeRdEn,
  input wire [7:0] storeAddr,
  output reg storeRdValid,
  output reg [15:0] storeRdData
);
  // Stored words, set by the bench
  reg [15:0] pinWord = 16'h0000;
  reg [15:0] funcWord = 16'h0000;
  // Answer delay in cycles; mute never answers
  integer delay = 0;
  integer cnt = 0;
  reg mute = 0;
  reg served = 0;
  initial storeRdValid = 0;
  initial storeRdData = 16'h0000;
  // One-cycle answer; data toggles when not valid
  always @(posedge sys_clk)
  begin
    storeRdValid <= 0;
    storeRdData <= ~storeRdData;
    if (!storeRdEn)
    begin
      cnt <= 0;
      served <= 0;
    end
    else if (!served && !mute)
    begin
      if (cnt >= delay)
      begin
        storeRdValid <= 1;
        served <= 1;
        // Word picked by address
        storeRdData <= (storeAddr == `NPL_FUNC_WORD_ADDR) ?
          funcWord : pinWord;
      end
      else
        cnt <= cnt + 1;
    end
  end
endmodule

// ==== dv/npl_config_loader_props.sv ====
// Port checker for the configuration loader.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`include "npl_consts.vh"
module npl_config_loader_props (
  // Clock and reset
  input wire sys_clk,
  input wire reset,
  input wire ce,
  // Store port
  input wire storeRdEn,
  input wire [7:0] storeAddr,
  input wire storeRdValid,
  // Device state
  input wire inActiveFullPower,
  input wire auxPowerPresentPin,
  input wire gigabitDisable,
  input wire coldWakeCapable,
  input wire legacyNarrowBaseMode,
  input wire prefetchableBaseMarking,
  input wire loadDone,
  input wire [1:0] softPinOe,
  // Bus handshakes
  input wire s_axi_awready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [1:0] s_axi_bresp
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  AST_RESET_STATE: assert property (disable iff (1'b0)
    reset |=> gigabitDisable && !loadDone && softPinOe == 2'h0)
    else $error("reset state wrong");
  AST_NO_EARLY_BUS: assert property (!loadDone |->
    !s_axi_awready && !s_axi_arready) else $error("bus open early");
  AST_DONE_STICKY: assert property (loadDone |=> loadDone)
    else $error("load done dropped");
  AST_STORE_ADDR: assert property (storeRdEn |->
    storeAddr == `NPL_PIN_WORD_ADDR || storeAddr == `NPL_FUNC_WORD_ADDR)
    else $error("store address wrong");
  AST_STORE_HOLD: assert property (storeRdEn && !storeRdValid
    |=> !storeRdEn || $stable(storeAddr)) else $error("address moved");
  AST_GIGA_FULL: assert property (loadDone && ce &&
    inActiveFullPower |=> !gigabitDisable) else $error("gigabit off");
  AST_COLD_NOAUX: assert property (!auxPowerPresentPin [*8]
    |-> !coldWakeCapable) else $error("wake without aux");
  AST_BAR_STABLE: assert property (loadDone && $past(loadDone)
    |-> $stable(legacyNarrowBaseMode) && $stable(prefetchableBaseMarking))
    else $error("base marking changed");
  AST_READ_LAT: assert property (s_axi_arvalid && s_axi_arready
    && ce |=> s_axi_rvalid) else $error("read answer late");
  AST_RDATA_HOLD: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
  AST_BRESP_HOLD: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp moved");
  // Main scenarios reached
  cover property ($rose(loadDone));
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property ($rose(coldWakeCapable));
endmodule
bind npl_config_loader npl_config_loader_props chk (.sys_clk(sys_clk),
  .reset(reset), .ce(ce), .storeRdEn(storeRdEn), .storeAddr(storeAddr),
  .storeRdValid(storeRdValid), .inActiveFullPower(inActiveFullPower),
  .auxPowerPresentPin(auxPowerPresentPin),
  .gigabitDisable(gigabitDisable), .coldWakeCapable(coldWakeCapable),
  .legacyNarrowBaseMode(legacyNarrowBaseMode),
  .prefetchableBaseMarking(prefetchableBaseMarking),
  .loadDone(loadDone), .softPinOe(softPinOe),
  .s_axi_awready(s_axi_awready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp));

// ==== dv/npl_config_loader_test.sv ====
// Self-checking bench for the configuration loader.
// Assumes the store model and the checker are compiled before it.
`timescale 1ns/1ps
`include "npl_consts.vh"
module npl_config_loader_test;
  // Clock, reset, power and pins
  reg sys_clk = 0;
  reg reset = 1;
  reg iafp = 1;
  reg aux = 0;
  reg [1:0] pinIn = 0;
  // Bus master side
  reg [7:0] awaddr = 0, araddr = 0;
  reg awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  reg [31:0] wdata = 0;
  reg [3:0] wstrb = 0;
  wire awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp, pinOut, pinOe;
  wire [31:0] rdata;
  // Store port and device state
  wire en, vld, giga, cold, narrow, pref, done;
  wire [7:0] sa;
  wire [15:0] sd;
  // Bench model state
  integer n_fail = 0, num_checks = 0, seed = 83, i, k;
  reg [15:0] pw, fw;
  reg [31:0] d, wv;
  reg [1:0] r;
  reg mute;
  always #2.5 sys_clk = ~sys_clk;
  npl_store_model sm (.sys_clk(sys_clk), .storeRdEn(en), .storeAddr(sa),
    .storeRdValid(vld), .storeRdData(sd));
  npl_config_loader uut (.sys_clk(sys_clk), .reset(reset), .ce(1'b1),
    .storeRdEn(en), .storeAddr(sa), .storeRdValid(vld), .storeRdData(sd),
    .inActiveFullPower(iafp), .auxPowerPresentPin(aux),
    .gigabitDisable(giga), .coldWakeCapable(cold),
    .legacyNarrowBaseMode(narrow), .prefetchableBaseMarking(pref),
    .loadDone(done), .softPinIn(pinIn), .softPinOut(pinOut),
    .softPinOe(pinOe), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  // Compare and count
  task chk(input string nm, input [31:0] e, input [31:0] g);
  begin
    num_checks = num_checks + 1;
    if (e !== g)
    begin
      n_fail = n_fail + 1;
      $display("mismatch %0s expected %h seen %h", nm, e, g);
    end
  end
  endtask
  // Expected response: aligned offsets up to the raw word are mapped
  function [1:0] expResp(input [7:0] a);
    expResp = (a <= `NPL_OFS_RAW && a[1:0] == 2'h0) ?
      `NPL_RESP_OKAY : `NPL_RESP_SLVERR;
  endfunction
  // Bus write; ready raised once the answer shows
  task axW(input [7:0] a, input [31:0] v, input [3:0] s);
  begin
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    awvalid <= 1;
    wvalid <= 1;
    while (!(bvalid && bready))
    begin
      @(posedge sys_clk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bvalid && !bready) bready <= 1;
    end
    r = bresp;
    bready <= 0;
    chk("writeResp", expResp(a), r);
  end
  endtask
  // Bus read
  task axR(input [7:0] a);
  begin
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1;
    while (!(rvalid && rready))
    begin
      @(posedge sys_clk);
      if (arvalid && arready) arvalid <= 0;
      if (rvalid && !rready) rready <= 1;
    end
    d = rdata;
    r = rresp;
    rready <= 0;
    chk("readResp", expResp(a), r);
  end
  endtask
  // Verdict and end of run
  task conclude;
  begin
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask
  // Watchdog against a hang
  initial
  begin
    repeat (30000) @(posedge sys_clk);
    n_fail = n_fail + 1;
    conclude;
  end
  // Main sequence: one load per pass, last pass store silent
  initial
  begin
    for (i = 0; i < 6; i = i + 1)
    begin
      mute = (i == 5);
      pw = $random(seed);
      fw = $random(seed);
      if (fw[9]) fw[10] = 0;
      sm.pinWord = pw;
      sm.funcWord = fw;
      sm.mute = mute;
      sm.delay = {$random(seed)} % 6;
      if (mute) pw = `NPL_PIN_WORD_RST;
      if (mute) fw = `NPL_FUNC_WORD_RST;
      @(posedge sys_clk);
      reset <= 1;
      pinIn <= $random(seed);
      repeat (5) @(posedge sys_clk);
      reset <= 0;
      for (k = 0; k < 1000 && done !== 1'b1; k = k + 1)
        @(posedge sys_clk);
      chk("loadDone", 1, done);
      axR(`NPL_OFS_CTRL);
      chk("ctrl", {pw[2], pw[9:8], pw[1:0]}, d);
      chk("pinOut", pw[1:0], pinOut);
      chk("pinOe", pw[9:8], pinOe);
      axR(`NPL_OFS_BASE_ADDRESS_CONTROL_REGISTER);
      chk("base_address_control_register", {fw[9], fw[10]}, d);
      chk("barPorts", {fw[9], fw[10]}, {pref, narrow});
      axR(`NPL_OFS_RAW);
      chk("rawFunc", fw & 16'h0600, d[31:16]);
      axR(`NPL_OFS_STATUS);
      chk("status", {1'b0, mute, 2'h3}, d[3:0]);
      aux <= 1;
      repeat (8) @(posedge sys_clk);
      chk("coldCap", pw[2], cold);
      axR(`NPL_OFS_PWRCAP);
      chk("pwrcap", pw[2], d);
      axR(`NPL_OFS_STATUS);
      chk("auxChg", 1, d[5]);
      chk("stLevels", {pinIn, 2'h3}, d[7:4]);
      axR(`NPL_OFS_STATUS);
      chk("auxChgClr", 0, d[5]);
      aux <= 0;
      repeat (8) @(posedge sys_clk);
      chk("coldOff", 0, cold);
      iafp <= 0;
      repeat (3) @(posedge sys_clk);
      chk("gigaLow", pw[3], giga);
      iafp <= 1;
      repeat (3) @(posedge sys_clk);
      chk("gigaFull", 0, giga);
      wv = $random(seed);
      axW(`NPL_OFS_CTRL, wv, 4'h1);
      chk("bresp", `NPL_RESP_OKAY, r);
      axR(`NPL_OFS_CTRL);
      chk("ctrlWr", {pw[2], wv[3:0]}, d);
      chk("pinOutWr", wv[3:0], {pinOe, pinOut});
      axW(`NPL_OFS_BASE_ADDRESS_CONTROL_REGISTER, ~wv, 4'hF);
      chk("barRO", {fw[9], fw[10]}, {pref, narrow});
      axR(8'h14);
      chk("unmapped", `NPL_RESP_SLVERR, r);
    end
    conclude;
  end
endmodule
